// ---- hdl/apfm_pkg.sv ----
package apfm_pkg;
   // system configuration selector codes
   typedef enum logic [1:0] {
      APFM_CFG_LINK = 2'h0, // proprietary codec serial link
      APFM_CFG_AC97 = 2'h1, // ac97 controller
      APFM_CFG_DAC = 2'h2, // external dac
      APFM_CFG_RSVD = 2'h3 // treated as codec link
   } apfm_cfg_t;
   // reset values
   localparam apfm_cfg_t APFM_CFG_RST = APFM_CFG_LINK;
   localparam logic APFM_EN_RST = 1'h0;
   localparam logic APFM_CRST_RST = 1'h0;
   localparam int APFM_AXES = 4;
   // timing counts
   localparam logic [1:0] APFM_STRAP_WAIT = 2'h2; // edges before the synchronised strap is valid
endpackage : apfm_pkg

// ---- hdl/apfm_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for pin inputs
module apfm_sync #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r; // first stage, read only by q
   // two stage capture
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : apfm_sync
`default_nettype wire

// ---- hdl/apfm_mux.sv ----
`timescale 1ns/10ps
`default_nettype none
// pin function mux for the audio accelerator side pins
module apfm_mux import apfm_pkg::*; #(
   parameter int AXES = APFM_AXES
) (
   input wire logic clock,
   input wire logic rst_n,
   // software configuration
   input wire logic [1:0] cfg_sel,
   input wire logic eeprom_present,
   input wire logic second_in_en,
   input wire logic second_out_en,
   input wire logic third_out_en,
   input wire logic alt_frame_en,
   input wire logic mclk_en,
   input wire logic osc_sel,
   input wire logic stick_en,
   input wire logic codec_reset_set,
   input wire logic codec_reset_clr,
   // internal sources
   input wire logic eeprom_clk_int,
   input wire logic eeprom_dat_drive_low,
   input wire logic general_io_two_drive_low,
   input wire logic general_output_val,
   input wire logic gpio_out_val,
   input wire logic gpio_out_oe,
   input wire logic [AXES-1:0] axis_drive_low,
   input wire logic second_out_int,
   input wire logic third_out_int,
   input wire logic alt_frame_int,
   input wire logic mclk_int,
   input wire logic bit_clock_int,
   input wire logic frame_int,
   input wire logic music_tx_int,
   // pins in
   input wire logic test_pin,
   input wire logic eeprom_serial_data_i,
   input wire logic second_serial_input_i,
   input wire logic volume_up_button_i,
   input wire logic volume_down_button_i,
   input wire logic [AXES-1:0] axis_i,
   input wire logic stick_a_button_one_i,
   input wire logic stick_a_button_two_i,
   input wire logic stick_b_button_one_i,
   input wire logic stick_b_button_two_i,
   input wire logic link_bit_clock_i,
   input wire logic link_frame_sync_i,
   input wire logic music_serial_in,
   // pins out
   output logic eeprom_serial_data_o,
   output logic eeprom_serial_data_oe,
   output logic eeprom_serial_clock,
   output logic second_serial_input_o,
   output logic second_serial_input_oe,
   output logic [AXES-1:0] axis_o,
   output logic [AXES-1:0] axis_oe,
   output logic stick_a_button_one_o,
   output logic stick_a_button_one_oe,
   output logic stick_a_button_two_o,
   output logic stick_a_button_two_oe,
   output logic stick_b_button_one_o,
   output logic stick_b_button_one_oe,
   output logic stick_b_button_two_o,
   output logic stick_b_button_two_oe,
   output logic link_bit_clock_o,
   output logic link_bit_clock_oe,
   output logic link_frame_sync_o,
   output logic link_frame_sync_oe,
   output logic music_serial_out,
   output logic codec_reset_n,
   // values back to the core
   output logic test_mode,
   output logic eeprom_data_in,
   output logic gpio_in,
   output logic vol_up_n,
   output logic vol_down_n,
   output logic [AXES-1:0] axis_in,
   output logic [3:0] buttons_n,
   output logic second_serial_in,
   output logic bit_clock_in,
   output logic frame_in,
   output logic music_rx
);
   localparam int NS = 12 + AXES; // synchronised pin count
   logic [NS-1:0] raw; // raw pin inputs
   logic [NS-1:0] syn; // synchronised pin inputs
   logic test_s; // synchronised strap
   logic strap_done_r; // strap already captured
   logic [1:0] strap_cnt_r; // edges since reset release
   apfm_cfg_t cfg_r; // current configuration
   logic [5:0] en_r; // function enables
   logic not_ac97; // expansion pins allowed
   logic is_dac; // external dac mode

   assign raw = {test_pin, eeprom_serial_data_i, second_serial_input_i, volume_up_button_i,
                 volume_down_button_i, axis_i, stick_a_button_one_i, stick_a_button_two_i,
                 stick_b_button_one_i, stick_b_button_two_i, link_bit_clock_i, link_frame_sync_i,
                 music_serial_in};
   assign test_s = syn[NS-1];

   // pin synchronisers
   apfm_sync #(.W(NS)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d(raw),
      .q(syn)
   );

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         strap_cnt_r <= 2'h0;
         strap_done_r <= 1'h0;
         test_mode <= 1'h0;
      end else if (strap_cnt_r != APFM_STRAP_WAIT) begin
         // synchroniser still holds its reset value, wait for the pin level
         strap_cnt_r <= strap_cnt_r + 2'h1;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'h1;
         test_mode <= test_s;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= APFM_CFG_RST;
         en_r <= {6{APFM_EN_RST}};
      end else begin
         cfg_r <= apfm_cfg_t'(cfg_sel);
         en_r <= {second_in_en, second_out_en, third_out_en, alt_frame_en, mclk_en, stick_en};
      end
   end

   assign not_ac97 = (cfg_r != APFM_CFG_AC97);
   assign is_dac = (cfg_r == APFM_CFG_DAC);

   // codec reset held low by bus reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         codec_reset_n <= APFM_CRST_RST;
      end else if (codec_reset_clr) begin
         codec_reset_n <= 1'h0;
      end else if (codec_reset_set) begin
         codec_reset_n <= 1'h1;
      end
   end

   // pin drivers, all registered
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         eeprom_serial_data_o <= 1'h0;
         eeprom_serial_data_oe <= 1'h0;
         eeprom_serial_clock <= 1'h0;
         second_serial_input_o <= 1'h0;
         second_serial_input_oe <= 1'h0;
         axis_o <= '0;
         axis_oe <= '0;
         stick_a_button_one_o <= 1'h0;
         stick_a_button_one_oe <= 1'h0;
         stick_a_button_two_o <= 1'h0;
         stick_a_button_two_oe <= 1'h0;
         stick_b_button_one_o <= 1'h0;
         stick_b_button_one_oe <= 1'h0;
         stick_b_button_two_o <= 1'h0;
         stick_b_button_two_oe <= 1'h0;
         link_bit_clock_o <= 1'h0;
         link_bit_clock_oe <= 1'h0;
         link_frame_sync_o <= 1'h0;
         link_frame_sync_oe <= 1'h0;
         music_serial_out <= 1'h1;
      end else begin
         // open drain, only ever drives low
         eeprom_serial_data_o <= 1'h0;
         eeprom_serial_data_oe <= eeprom_present ? eeprom_dat_drive_low : general_io_two_drive_low;
         eeprom_serial_clock <= eeprom_present ? eeprom_clk_int : general_output_val;
         second_serial_input_o <= gpio_out_val;
         second_serial_input_oe <= !(en_r[5] && not_ac97) && gpio_out_oe;
         // axes open drain when stick unused
         axis_o <= '0;
         axis_oe <= en_r[0] ? '0 : axis_drive_low;
         stick_a_button_one_o <= second_out_int;
         stick_a_button_one_oe <= en_r[4] && not_ac97;
         stick_a_button_two_o <= third_out_int;
         stick_a_button_two_oe <= en_r[3] && not_ac97;
         stick_b_button_one_o <= alt_frame_int;
         stick_b_button_one_oe <= en_r[2] && not_ac97;
         stick_b_button_two_o <= mclk_int;
         stick_b_button_two_oe <= en_r[1] && not_ac97;
         // bit clock drives only for dac
         link_bit_clock_o <= bit_clock_int;
         link_bit_clock_oe <= is_dac;
         // frame input only in codec link
         link_frame_sync_o <= frame_int;
         link_frame_sync_oe <= (cfg_r == APFM_CFG_AC97) || is_dac;
         music_serial_out <= music_tx_int;
      end
   end

   // input returns to the core
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         eeprom_data_in <= 1'h1;
         gpio_in <= 1'h0;
         vol_up_n <= 1'h1;
         vol_down_n <= 1'h1;
         axis_in <= '0;
         buttons_n <= 4'hF;
         second_serial_in <= 1'h0;
         bit_clock_in <= 1'h0;
         frame_in <= 1'h0;
         music_rx <= 1'h1;
      end else begin
         eeprom_data_in <= syn[NS-2];
         gpio_in <= syn[NS-3];
         second_serial_in <= (en_r[5] && not_ac97) ? syn[NS-3] : 1'h0;
         vol_up_n <= osc_sel ? 1'h1 : syn[NS-4];
         vol_down_n <= osc_sel ? 1'h1 : syn[NS-5];
         axis_in <= syn[NS-6 -: AXES];
         buttons_n <= syn[6:3];
         bit_clock_in <= syn[2];
         frame_in <= is_dac ? 1'h0 : syn[1];
         // music receiver, synchronised like every pin
         music_rx <= syn[0];
      end
   end

   // a_sdo_ac97 checks that ac97 mode blocks both stick a button expansion outputs
   a_sdo_ac97_block: assert property (@(posedge clock) disable iff (!rst_n)
      $past(cfg_r) == APFM_CFG_AC97 |-> !stick_a_button_one_oe && !stick_a_button_two_oe)
      else $error("expansion output driven in ac97 mode");
   a_bclk_dac_drive: assert property (@(posedge clock) disable iff (!rst_n)
      link_bit_clock_oe == ($past(cfg_r) == APFM_CFG_DAC))
      else $error("bit clock drive wrong for mode");
   a_eeprom_low_only: assert property (@(posedge clock) disable iff (!rst_n)
      eeprom_serial_data_oe |-> !eeprom_serial_data_o)
      else $error("eeprom data driven high");
   a_crst_hold_low: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(codec_reset_n) |-> $past(codec_reset_set) && !$past(codec_reset_clr))
      else $error("codec reset released without software");
   // strap settles through the synchroniser, then is taken once
   sequence s_strap_ready;
      strap_cnt_r == APFM_STRAP_WAIT && !strap_done_r;
   endsequence
   a_strap_capture: assert property (@(posedge clock) disable iff (!rst_n)
      s_strap_ready |=> test_mode == $past(test_s))
      else $error("test mode differs from the sampled strap");
   a_strap_hold: assert property (@(posedge clock) disable iff (!rst_n)
      strap_done_r |=> $stable(test_mode))
      else $error("test mode changed after strap capture");
   a_frame_drive_mode: assert property (@(posedge clock) disable iff (!rst_n)
      link_frame_sync_oe == ($past(cfg_r) == APFM_CFG_AC97 || $past(cfg_r) == APFM_CFG_DAC))
      else $error("frame drive wrong for mode");
endmodule : apfm_mux
`default_nettype wire

// ---- tb/apfm_far_side.sv ----
`timescale 1ns/10ps
`default_nettype none
// far-side devices: pull-ups on open-drain lines, drivers on released pins
module apfm_far_side (
   input wire logic far_lvl,
   input wire logic eeprom_serial_data_oe,
   input wire logic [3:0] axis_oe,
   input wire logic second_serial_input_o,
   input wire logic second_serial_input_oe,
   input wire logic stick_a_button_one_o,
   input wire logic stick_a_button_one_oe,
   input wire logic stick_a_button_two_o,
   input wire logic stick_a_button_two_oe,
   input wire logic stick_b_button_one_o,
   input wire logic stick_b_button_one_oe,
   input wire logic stick_b_button_two_o,
   input wire logic stick_b_button_two_oe,
   input wire logic link_bit_clock_o,
   input wire logic link_bit_clock_oe,
   input wire logic link_frame_sync_o,
   input wire logic link_frame_sync_oe,
   output logic eeprom_serial_data_i,
   output logic [3:0] axis_i,
   output logic second_serial_input_i,
   output logic stick_a_button_one_i,
   output logic stick_a_button_two_i,
   output logic stick_b_button_one_i,
   output logic stick_b_button_two_i,
   output logic link_bit_clock_i,
   output logic link_frame_sync_i
);
   assign eeprom_serial_data_i = ~eeprom_serial_data_oe & far_lvl;
   assign axis_i = ~axis_oe & {4{far_lvl}};
   // far device drives only a released pin
   assign second_serial_input_i = second_serial_input_oe ? second_serial_input_o : far_lvl;
   assign stick_a_button_one_i = stick_a_button_one_oe ? stick_a_button_one_o : far_lvl;
   assign stick_a_button_two_i = stick_a_button_two_oe ? stick_a_button_two_o : far_lvl;
   assign stick_b_button_one_i = stick_b_button_one_oe ? stick_b_button_one_o : far_lvl;
   assign stick_b_button_two_i = stick_b_button_two_oe ? stick_b_button_two_o : far_lvl;
   assign link_bit_clock_i = link_bit_clock_oe ? link_bit_clock_o : far_lvl;
   assign link_frame_sync_i = link_frame_sync_oe ? link_frame_sync_o : far_lvl;
endmodule : apfm_far_side
`default_nettype wire

// ---- tb/tb_audio_pin_function_mux.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_audio_pin_function_mux;
   logic clock = 0, rst_n, far_lvl, test_pin;
   logic [1:0] cfg_sel;
   logic [3:0] axis_drive_low, axis_i, axis_o, axis_oe, axis_in, buttons_n;
   logic eeprom_present, second_in_en, second_out_en, third_out_en, alt_frame_en, mclk_en, osc_sel, stick_en;
   logic codec_reset_set, codec_reset_clr, eeprom_clk_int, eeprom_dat_drive_low, general_io_two_drive_low;
   logic general_output_val, gpio_out_val, gpio_out_oe, second_out_int, third_out_int, alt_frame_int;
   logic mclk_int, bit_clock_int, frame_int;
   logic music_tx_int, eeprom_serial_data_i, second_serial_input_i, volume_up_button_i, volume_down_button_i;
   logic stick_a_button_one_i, stick_a_button_two_i, stick_b_button_one_i, stick_b_button_two_i;
   logic link_bit_clock_i, link_frame_sync_i, music_serial_in, eeprom_serial_data_o, eeprom_serial_data_oe;
   logic eeprom_serial_clock, second_serial_input_o, second_serial_input_oe, stick_a_button_one_o;
   logic stick_a_button_one_oe, stick_a_button_two_o, stick_a_button_two_oe, stick_b_button_one_o;
   logic stick_b_button_one_oe, stick_b_button_two_o, stick_b_button_two_oe, link_bit_clock_o;
   logic link_bit_clock_oe, link_frame_sync_o, link_frame_sync_oe, music_serial_out, codec_reset_n;
   logic test_mode, eeprom_data_in, gpio_in, vol_up_n, vol_down_n, second_serial_in, bit_clock_in;
   logic frame_in, music_rx;
   int n_mismatch = 0;
   int checks_done = 0;
   // 125 MHz clock
   always #4 clock = ~clock;
   apfm_mux dut (.*);
   apfm_far_side far (.*);
   // compare and count
   task automatic ck(input logic [3:0] g, input logic [3:0] e);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : ck
   task automatic st(input int n);
      repeat (n) @(negedge clock);
   endtask : st
   // verdict and end of run
   task automatic results;
      if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   // reset with all software inputs cleared
   task automatic t_reset(input logic tp);
      rst_n = 0;
      test_pin = tp;
      far_lvl = 1;
      {cfg_sel, eeprom_present, second_in_en, second_out_en, third_out_en, alt_frame_en, mclk_en, osc_sel,
       stick_en, codec_reset_set, codec_reset_clr, eeprom_clk_int, eeprom_dat_drive_low, general_io_two_drive_low,
       general_output_val, gpio_out_val, gpio_out_oe, axis_drive_low, second_out_int, third_out_int,
       alt_frame_int, mclk_int, bit_clock_int, frame_int, music_tx_int, volume_up_button_i, volume_down_button_i,
       music_serial_in} = '0;
      st(20);
      ck({codec_reset_n, link_bit_clock_oe, eeprom_serial_data_oe, music_serial_out}, 4'h1);
      rst_n = 1;
      st(4);
      ck({3'h0, test_mode}, {3'h0, tp});
      ck({link_bit_clock_oe, link_frame_sync_oe, stick_a_button_one_oe, codec_reset_n}, 4'h0);
      // strap is not sampled again after reset
      test_pin = !tp;
      st(4);
      ck({3'h0, test_mode}, {3'h0, tp});
   endtask : t_reset
   // open drain, general outputs, volume and music pins
   task automatic t_pins;
      {general_io_two_drive_low, general_output_val, gpio_out_oe, gpio_out_val, music_serial_in} = 5'h1F;
      axis_drive_low = 4'h6;
      st(4);
      ck({eeprom_serial_data_oe, eeprom_serial_data_o, eeprom_serial_clock, eeprom_data_in}, 4'hA);
      ck(axis_oe, 4'h6);
      ck(axis_o & axis_oe, 4'h0);
      ck(axis_in, 4'h9);
      ck(buttons_n, 4'hF);
      ck({second_serial_input_oe, second_serial_input_o, gpio_in, 1'h0}, 4'hE);
      ck({vol_up_n, vol_down_n, music_rx, music_serial_out}, 4'h2);
      {eeprom_present, eeprom_clk_int, stick_en, osc_sel, general_output_val, general_io_two_drive_low} = 6'h3C;
      st(4);
      ck({eeprom_serial_data_oe, eeprom_serial_clock, axis_oe[1], axis_oe[2]}, 4'h4);
      ck({vol_up_n, vol_down_n, 2'h0}, 4'hC);
   endtask : t_pins
   // every configuration with all expansion enables set
   task automatic t_cfg;
      {second_out_en, third_out_en, alt_frame_en, mclk_en, second_in_en} = 5'h1F;
      for (int i = 0; i < 4; i++) begin
         cfg_sel = 2'(i);
         {second_out_int, third_out_int, alt_frame_int, mclk_int} = 4'(i * 5 + 3);
         {bit_clock_int, frame_int} = 2'(i);
         st(4);
         ck({stick_a_button_one_oe, stick_a_button_two_oe, stick_b_button_one_oe, stick_b_button_two_oe},
            (i == 1) ? 4'h0 : 4'hF);
         if (i != 1) ck({stick_a_button_one_o, stick_a_button_two_o, stick_b_button_one_o, stick_b_button_two_o},
            4'(i * 5 + 3));
         ck({link_bit_clock_oe, link_frame_sync_oe, second_serial_input_oe, 1'h0},
            {i == 2, i == 1 || i == 2, i == 1, 1'h0});
         ck({link_bit_clock_o, link_frame_sync_o, 2'h0}, {2'(i), 2'h0});
      end
      far_lvl = 0;
      st(4);
      ck({second_serial_in, bit_clock_in, frame_in, 1'h0}, 4'h0);
      far_lvl = 1;
      st(4);
      ck({second_serial_in, bit_clock_in, frame_in, 1'h0}, 4'hE);
   endtask : t_cfg
   // software release of the codec reset, clear wins
   task automatic t_codec;
      codec_reset_set = 1;
      st(1);
      codec_reset_set = 0;
      st(3);
      ck({3'h0, codec_reset_n}, 4'h1);
      {codec_reset_set, codec_reset_clr} = 2'h3;
      st(4);
      ck({3'h0, codec_reset_n}, 4'h0);
      codec_reset_clr = 0;
      st(4);
      ck({3'h0, codec_reset_n}, 4'h1);
   endtask : t_codec
   initial begin
      t_reset(0);
      t_pins;
      t_cfg;
      t_codec;
      t_reset(1);
      results;
   end
endmodule : tb_audio_pin_function_mux
`default_nettype wire
